/* File: ssi_pkg.sv */
// Shared constants and helpers for the serial absolute position link.
package ssi_pkg;

  // ----------------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned RATE_0_HZ = 201_600;
  localparam int unsigned RATE_1_HZ = 500_000;
  localparam int unsigned RATE_2_HZ = 1_042_000;
  localparam int unsigned RATE_3_HZ = 1_560_000;
  localparam int unsigned HALF_W = 9;
  // Slave gives up on a frame when the clock is quiet this long.
  localparam int unsigned FRAME_TIMEOUT_US = 20;
  localparam int unsigned FRAME_TIMEOUT_CYC =
    FRAME_TIMEOUT_US * (CLK_HZ / 1_000_000);
  // Master pause after a frame; longer than the slave timeout.
  localparam int unsigned FRAME_GAP_US = 25;
  localparam int unsigned FRAME_GAP_CYC = FRAME_GAP_US * (CLK_HZ / 1_000_000);
  localparam int unsigned TIMER_W = 12;

  // ----------------------------------------------------------------------
  // Frame layouts and control bits
  // ----------------------------------------------------------------------
  localparam logic [2:0] LAYOUT_12_TURNS_12_ANGLE = 3'h0;
  localparam logic [2:0] LAYOUT_8_TURNS_16_ANGLE = 3'h1;
  localparam logic [2:0] LAYOUT_10_TURNS_20_ANGLE = 3'h2;
  localparam logic [2:0] LAYOUT_25_BIT = 3'h3;
  localparam logic [2:0] LAYOUT_23_BIT = 3'h4;
  localparam int unsigned TURN_W = 12;
  localparam int unsigned ANGLE_W = 20;
  localparam int unsigned WORD_W = 32;
  localparam int unsigned CNT_W = 6;
  localparam int unsigned CTL_RATE_LSB = 0;
  localparam int unsigned CTL_IDLE_HIGH = 2;
  localparam int unsigned CTL_SAMPLE_FIRST = 3;
  localparam int unsigned CTL_GRAY = 4;

  // ----------------------------------------------------------------------
  // Register map of the link master
  // ----------------------------------------------------------------------
  localparam logic [7:0] REG_CONFIG = 8'h00;
  localparam logic [7:0] REG_COMMAND = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_TURNS = 8'h0C;
  localparam logic [7:0] REG_ANGLE = 8'h10;
  localparam int unsigned CFG_LAYOUT_LSB = 0;
  localparam int unsigned CFG_CTRL_LSB = 8;
  localparam int unsigned CMD_START = 0;
  localparam int unsigned STAT_BUSY = 0;
  localparam int unsigned STAT_DONE = 1;

  // Unknown layout codes fall back to the default layout.
  function automatic logic [2:0] layout_sel(input logic [7:0] code);
    layout_sel = (code <= 8'(LAYOUT_23_BIT)) ? code[2:0] :
                 LAYOUT_12_TURNS_12_ANGLE;
  endfunction

  function automatic logic [CNT_W-1:0] turn_bits(input logic [2:0] code);
    case (code)
      LAYOUT_8_TURNS_16_ANGLE: turn_bits = 6'h08;
      LAYOUT_10_TURNS_20_ANGLE: turn_bits = 6'h0A;
      LAYOUT_23_BIT: turn_bits = 6'h0A;
      default: turn_bits = 6'h0C;
    endcase
  endfunction

  function automatic logic [CNT_W-1:0] angle_bits(input logic [2:0] code);
    case (code)
      LAYOUT_8_TURNS_16_ANGLE: angle_bits = 6'h10;
      LAYOUT_10_TURNS_20_ANGLE: angle_bits = 6'h14;
      LAYOUT_25_BIT: angle_bits = 6'h0D;
      LAYOUT_23_BIT: angle_bits = 6'h0D;
      default: angle_bits = 6'h0C;
    endcase
  endfunction

  function automatic logic [WORD_W-1:0] low_mask(input logic [CNT_W-1:0] n);
    low_mask = (WORD_W'(1) << n) - WORD_W'(1);
  endfunction

  // Half period of the link clock in system clock cycles, rounded down.
  function automatic logic [HALF_W-1:0] half_cycles(input logic [1:0] rate);
    case (rate)
      2'h0: half_cycles = HALF_W'(CLK_HZ / (2 * RATE_0_HZ));
      2'h1: half_cycles = HALF_W'(CLK_HZ / (2 * RATE_1_HZ));
      2'h2: half_cycles = HALF_W'(CLK_HZ / (2 * RATE_2_HZ));
      default: half_cycles = HALF_W'(CLK_HZ / (2 * RATE_3_HZ));
    endcase
  endfunction

endpackage

/* File: ssi_link_if.sv */
// Link wires between the position source and the link master.
`timescale 1ns/1ps
`default_nettype none
interface ssi_link_if;
  logic ssi_clk;
  logic ssi_data;
  logic ssi_data_en;
  modport position_source (input ssi_clk, output ssi_data, output ssi_data_en);
  modport position_reader (output ssi_clk, input ssi_data, input ssi_data_en);
endinterface
`default_nettype wire

/* File: ssi_position_slave.sv */
// Position source end: answers master clock pulses with the shaft position.
`timescale 1ns/1ps
`default_nettype none
module ssi_position_slave
  import ssi_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYC = FRAME_TIMEOUT_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Link
  ssi_link_if.position_source link,
  // Position and configuration
  input wire logic [TURN_W-1:0] turns_i,
  input wire logic [ANGLE_W-1:0] angle_i,
  input wire logic [7:0] frame_layout_code_i,
  input wire logic [7:0] link_control_bits_i,
  // Port function selection
  input wire logic serial_mode_i,
  input wire logic htl_master_select_i,
  output logic incremental_sim_en_o,
  output logic master_input_en_o,
  output logic frame_active_o
);

  // ----------------------------------------------------------------------
  // Port function selection
  // ----------------------------------------------------------------------
  logic ssi_en;
  assign ssi_en = serial_mode_i && !htl_master_select_i; // [RULE_10]
  assign incremental_sim_en_o = !serial_mode_i &&
                                !htl_master_select_i; // [RULE_10] [RULE_11]
  assign master_input_en_o = !htl_master_select_i; // [RULE_11]

  // ----------------------------------------------------------------------
  // Link clock synchroniser and edge detection
  // ----------------------------------------------------------------------
  logic clk_s1_q;
  logic clk_s2_q;
  logic clk_s3_q;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      clk_s1_q <= 1'b0;
      clk_s2_q <= 1'b0;
      clk_s3_q <= 1'b0;
    end else begin
      clk_s1_q <= link.ssi_clk;
      clk_s2_q <= clk_s1_q;
      clk_s3_q <= clk_s2_q;
    end
  end

  logic idle_lvl;
  logic any_edge;
  logic first_edge;
  logic second_edge;
  logic shift_edge;
  assign idle_lvl = link_control_bits_i[CTL_IDLE_HIGH]; // [RULE_13]
  assign any_edge = clk_s2_q != clk_s3_q;
  // The first edge of a pulse leaves the idle level, the second returns.
  assign first_edge = any_edge && (clk_s2_q != idle_lvl); // [RULE_13]
  assign second_edge = any_edge && (clk_s2_q == idle_lvl);
  assign shift_edge = link_control_bits_i[CTL_SAMPLE_FIRST] ?
                      second_edge : first_edge; // [RULE_09]

  // ----------------------------------------------------------------------
  // Position word
  // ----------------------------------------------------------------------
  logic [2:0] layout;
  logic [CNT_W-1:0] tbits;
  logic [CNT_W-1:0] abits;
  logic [CNT_W-1:0] nbits;
  logic [WORD_W-1:0] word;

  assign layout = layout_sel(frame_layout_code_i);
  assign tbits = turn_bits(layout); // [RULE_03] [RULE_04]
  assign abits = angle_bits(layout); // [RULE_05] [RULE_06] [RULE_07]
  assign nbits = tbits + abits;

  always_comb begin
    word = ((WORD_W'(turns_i) & low_mask(tbits)) << abits) |
           (WORD_W'(angle_i) & low_mask(abits)); // [RULE_08]
    // Left align so the most significant frame bit leaves first.
    word = word << (CNT_W'(WORD_W) - nbits); // [RULE_08]
    if (link_control_bits_i[CTL_GRAY]) begin
      word = word ^ (word >> 1); // [RULE_13]
    end
  end

  // ----------------------------------------------------------------------
  // Frame sequencing
  // ----------------------------------------------------------------------
  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_SHIFT = 1'b1
  } frame_state_e;

  frame_state_e state_q;
  logic [WORD_W-1:0] shreg_q;
  logic [CNT_W-1:0] bits_left_q;
  logic [CNT_W-1:0] pulses_q;
  logic [CNT_W-1:0] frame_bits_q;
  logic [TIMER_W-1:0] quiet_q;
  logic data_q;
  logic timed_out;
  logic frame_end;

  assign timed_out = state_q == ST_SHIFT && quiet_q == TIMER_W'(TIMEOUT_CYC);
  // The frame closes on the second edge of the last pulse: bits plus one.
  assign frame_end = second_edge && pulses_q == frame_bits_q; // [RULE_03]

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      quiet_q <= '0;
    end else if (any_edge || state_q == ST_IDLE) begin
      quiet_q <= '0;
    end else if (!timed_out) begin
      quiet_q <= quiet_q + TIMER_W'(1);
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_q <= ST_IDLE;
      shreg_q <= '0;
      bits_left_q <= '0;
      pulses_q <= '0;
      frame_bits_q <= '0;
      data_q <= 1'b1;
    end else begin
      case (state_q)
        ST_IDLE: begin
          data_q <= 1'b1;
          // The master opens every frame; nothing is sent unprompted.
          if (ssi_en && first_edge) begin // [RULE_01]
            shreg_q <= word; // [RULE_02]
            bits_left_q <= nbits;
            frame_bits_q <= nbits;
            pulses_q <= '0;
            state_q <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          if (!ssi_en || timed_out || frame_end) begin
            data_q <= 1'b1;
            state_q <= ST_IDLE;
          end else begin
            if (second_edge) begin
              pulses_q <= pulses_q + CNT_W'(1);
            end
            if (shift_edge && bits_left_q != '0) begin // [RULE_09]
              data_q <= shreg_q[WORD_W-1]; // [RULE_08]
              shreg_q <= shreg_q << 1;
              bits_left_q <= bits_left_q - CNT_W'(1);
            end
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  // The data line is released while the port serves another function.
  assign link.ssi_data = data_q;
  assign link.ssi_data_en = ssi_en;
  assign frame_active_o = state_q == ST_SHIFT;

endmodule
`default_nettype wire

/* File: ssi_position_master.sv */
// Link master end: makes the link clock and reads position frames.
//
// Function
// [RULE_01] Slave only; master makes every clock pulse.
// [RULE_02] Extra leading pulse latches position into shifter.
// [RULE_03] Code 0: 12 turns, 12 angle, 25 pulses.
// [RULE_04] Code 1: 8 turns, 16 angle, 25 pulses.
// [RULE_05] Code 2: 10 turns, 20 angle, 31 pulses.
// [RULE_06] Code 3: 12 turns, 13 angle, 26 pulses.
// [RULE_07] Code 4: 10 turns, 13 angle, 24 pulses.
// [RULE_08] MSB first, turns field ahead of angle.
// [RULE_09] Bit 3 picks shift edge versus sample edge.
// [RULE_10] Serial output replaces incremental simulation, exclusive.
// [RULE_11] 24 V master input disables both port functions.
// [RULE_12] Bits 0-1 select link bit rate.
// [RULE_13] Bit 2 idle clock level, bit 4 Gray coding.
//
// Added by the designer: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module ssi_position_master
  import ssi_pkg::*;
#(
  parameter int unsigned GAP_CYC = FRAME_GAP_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Link
  ssi_link_if.position_reader link
);

  // ----------------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------------
  logic wr_q;
  logic [7:0] addr_q;
  logic [2:0] layout_cfg_q;
  logic [4:0] ctrl_cfg_q;
  logic start;
  logic done_q;
  logic busy;
  logic frame_done;
  logic [WORD_W-1:0] pos_q;
  logic [2:0] layout;
  logic [CNT_W-1:0] tbits;
  logic [CNT_W-1:0] abits;
  logic [CNT_W-1:0] nbits;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_q <= 1'b0;
      addr_q <= '0;
    end else begin
      wr_q <= hsel && hready && htrans[1] && hwrite;
      addr_q <= haddr[7:0];
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      layout_cfg_q <= LAYOUT_12_TURNS_12_ANGLE;
      ctrl_cfg_q <= '0;
    end else if (wr_q && addr_q == REG_CONFIG) begin
      layout_cfg_q <= hwdata[CFG_LAYOUT_LSB +: 3];
      ctrl_cfg_q <= hwdata[CFG_CTRL_LSB +: 5];
    end
  end

  assign start = wr_q && addr_q == REG_COMMAND && hwdata[CMD_START];

  // A frame that ends in the clearing cycle keeps the flag set.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      done_q <= 1'b0;
    end else if (frame_done) begin
      done_q <= 1'b1;
    end else if (wr_q && addr_q == REG_STATUS && hwdata[STAT_DONE]) begin
      done_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      hrdata <= '0;
    end else if (hsel && hready && htrans[1] && !hwrite) begin
      if (haddr[7:0] == REG_CONFIG) begin
        hrdata <= (32'(layout_cfg_q) << CFG_LAYOUT_LSB) |
                  (32'(ctrl_cfg_q) << CFG_CTRL_LSB);
      end else if (haddr[7:0] == REG_STATUS) begin
        hrdata <= (32'(busy) << STAT_BUSY) | (32'(done_q) << STAT_DONE);
      end else if (haddr[7:0] == REG_TURNS) begin
        hrdata <= (pos_q >> abits) & low_mask(tbits);
      end else if (haddr[7:0] == REG_ANGLE) begin
        hrdata <= pos_q & low_mask(abits);
      end else begin
        hrdata <= '0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Link clock generation and sampling
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ACTIVE = 2'b01,
    ST_REST = 2'b11,
    ST_GAP = 2'b10
  } link_state_e;

  link_state_e state_q;
  logic [TIMER_W-1:0] tmr_q;
  logic [CNT_W-1:0] pulse_q;
  logic [WORD_W-1:0] rx_q;
  logic [WORD_W-1:0] bin;
  logic sclk_q;
  logic din_s1_q;
  logic din_s2_q;
  logic half_done;
  logic sample_first;

  assign layout = layout_sel(8'(layout_cfg_q));
  assign tbits = turn_bits(layout); // [RULE_03]
  assign abits = angle_bits(layout);
  assign nbits = tbits + abits;
  assign sample_first = ctrl_cfg_q[CTL_SAMPLE_FIRST];
  assign half_done = tmr_q + TIMER_W'(1) == // [RULE_12]
                     TIMER_W'(half_cycles(ctrl_cfg_q[CTL_RATE_LSB +: 2]));
  assign busy = state_q != ST_IDLE;
  assign frame_done = state_q == ST_REST && half_done && pulse_q == nbits;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      din_s1_q <= 1'b1;
      din_s2_q <= 1'b1;
    end else begin
      din_s1_q <= link.ssi_data;
      din_s2_q <= din_s1_q;
    end
  end

  // Gray words are decoded over the whole WORD_W-bit receive register.
  assign bin[WORD_W-1] = rx_q[WORD_W-1];
  for (genvar g = 0; g < WORD_W - 1; g++) begin : g_gray
    assign bin[g] = bin[g+1] ^ rx_q[g];
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pos_q <= '0;
    end else if (frame_done) begin
      pos_q <= ctrl_cfg_q[CTL_GRAY] ? bin : rx_q; // [RULE_13]
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_q <= ST_IDLE;
      tmr_q <= '0;
      pulse_q <= '0;
      rx_q <= '0;
      sclk_q <= 1'b0;
    end else begin
      tmr_q <= tmr_q + TIMER_W'(1);
      case (state_q)
        ST_IDLE: begin
          sclk_q <= ctrl_cfg_q[CTL_IDLE_HIGH]; // [RULE_13]
          tmr_q <= '0;
          if (start) begin // [RULE_01]
            sclk_q <= !ctrl_cfg_q[CTL_IDLE_HIGH];
            pulse_q <= '0;
            rx_q <= '0;
            state_q <= ST_ACTIVE;
          end
        end
        ST_ACTIVE: begin
          if (half_done) begin
            tmr_q <= '0;
            sclk_q <= ctrl_cfg_q[CTL_IDLE_HIGH];
            state_q <= ST_REST;
            // Pulse zero is the latch pulse and carries no data bit.
            if (!sample_first && pulse_q != '0) begin // [RULE_02] [RULE_09]
              rx_q <= {rx_q[WORD_W-2:0], din_s2_q};
            end
          end
        end
        ST_REST: begin
          if (half_done) begin
            tmr_q <= '0;
            if (pulse_q == nbits) begin // [RULE_03] [RULE_05]
              state_q <= ST_GAP;
            end else begin
              pulse_q <= pulse_q + CNT_W'(1);
              sclk_q <= !ctrl_cfg_q[CTL_IDLE_HIGH];
              state_q <= ST_ACTIVE;
              if (sample_first) begin // [RULE_09]
                rx_q <= {rx_q[WORD_W-2:0], din_s2_q};
              end
            end
          end
        end
        ST_GAP: begin
          if (tmr_q == TIMER_W'(GAP_CYC)) begin
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  assign link.ssi_clk = sclk_q;

endmodule
`default_nettype wire

/* File: ssi_link_properties.sv */
// Concurrent checks on the position link.
`timescale 1ns/1ps
`default_nettype none
module ssi_link_properties
  import ssi_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Link
  input wire logic ssi_clk,
  input wire logic ssi_data,
  input wire logic ssi_data_en,
  // Slave side
  input wire logic [7:0] link_control_bits_i,
  input wire logic serial_mode_i,
  input wire logic htl_master_select_i,
  input wire logic incremental_sim_en_o,
  input wire logic master_input_en_o,
  input wire logic frame_active_o
);
  // ----------------------------------------------------------------------
  // Helper logic
  // ----------------------------------------------------------------------
  // Edge lag covers two sync stages and the slave's data register.
  localparam int MIN_SINCE = 39;
  localparam int EDGE_LAG = 6;
  logic clk_prev_q;
  logic [9:0] since_q;
  logic first_q;
  logic chg;
  assign chg = ssi_clk != clk_prev_q;
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) clk_prev_q <= 1'b0;
    else clk_prev_q <= ssi_clk;
  end
  // Saturates so that a long idle span never wraps to a small count.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) since_q <= 10'h3FF;
    else if (chg) since_q <= 10'h000;
    else if (since_q != 10'h3FF) since_q <= since_q + 10'h001;
  end
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) first_q <= 1'b0;
    else if (chg) first_q <= ssi_clk != link_control_bits_i[CTL_IDLE_HIGH];
  end
  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  AST_SIM_EXCLUSIVE: assert property (
    incremental_sim_en_o == (!serial_mode_i && !htl_master_select_i))
    else $error("incremental output enable wrong");
  AST_DATA_EN_SERIAL: assert property (
    ssi_data_en == (serial_mode_i && !htl_master_select_i))
    else $error("serial data enable wrong");
  AST_HTL_DISABLES: assert property (
    htl_master_select_i |-> !master_input_en_o && !ssi_data_en)
    else $error("port functions not off under 24 V input");
  AST_NO_FRAME_DISABLED: assert property (
    !ssi_data_en && !frame_active_o |=> !frame_active_o)
    else $error("frame started while serial output is off");
  AST_FRAME_ON_PULSE: assert property (
    $rose(frame_active_o) |-> since_q <= EDGE_LAG)
    else $error("frame start not tied to a clock edge");
  AST_DATA_AFTER_EDGE: assert property (
    ssi_data_en && $past(ssi_data_en) && $changed(ssi_data)
    |-> since_q <= EDGE_LAG)
    else $error("data changed away from a clock edge");
  AST_SHIFT_EDGE_SELECT: assert property (
    $fell(ssi_data) && frame_active_o
    |-> first_q == !link_control_bits_i[CTL_SAMPLE_FIRST])
    else $error("data shifted on the sampling edge");
  AST_IDLE_DATA_HIGH: assert property (
    (ssi_data_en && !frame_active_o) [*3] |-> ssi_data)
    else $error("data line not high outside a frame");
  AST_HALF_PERIOD: assert property (
    chg && frame_active_o |-> since_q >= MIN_SINCE)
    else $error("link clock half period too short");
  // ----------------------------------------------------------------------
  // Cover points
  // ----------------------------------------------------------------------
  COV_FRAME: cover property ($rose(frame_active_o));
  COV_SAMPLE_FIRST: cover property (
    $fell(ssi_data) && link_control_bits_i[CTL_SAMPLE_FIRST]);
  COV_HTL: cover property (htl_master_select_i && serial_mode_i);
endmodule
`default_nettype wire

/* File: ssi_slave_position_output_tb_top.sv */
// Testbench joining link master and position slave.
`timescale 1ns/1ps
`default_nettype none
module ssi_slave_position_output_tb_top
  import ssi_pkg::*;
;
  // ----------------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------------
  logic clk_i = 1'b0;
  logic rst_b_i, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, wire_word, half_meas;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [11:0] turns_i;
  logic [19:0] angle_i;
  logic [7:0] code_i, ctl_i;
  logic serial_mode_i, htl_i, inc_en, mst_en, act;
  logic mon_on, idle_lvl, smp_first, mprev, saw_act;
  int mismatches, n_checks, pulses, run;
  always #4 clk_i = ~clk_i;
  // ----------------------------------------------------------------------
  // Design
  // ----------------------------------------------------------------------
  ssi_link_if ssi_link_if_i ();
  ssi_position_slave #(.TIMEOUT_CYC(400)) ssi_position_slave_i (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .link(ssi_link_if_i),
    .turns_i(turns_i), .angle_i(angle_i), .frame_layout_code_i(code_i),
    .link_control_bits_i(ctl_i), .serial_mode_i(serial_mode_i),
    .htl_master_select_i(htl_i), .incremental_sim_en_o(inc_en),
    .master_input_en_o(mst_en), .frame_active_o(act));
  ssi_position_master #(.GAP_CYC(500)) ssi_position_master_i (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .link(ssi_link_if_i));
  ssi_link_properties ssi_link_properties_i (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .ssi_clk(ssi_link_if_i.ssi_clk),
    .ssi_data(ssi_link_if_i.ssi_data),
    .ssi_data_en(ssi_link_if_i.ssi_data_en), .link_control_bits_i(ctl_i),
    .serial_mode_i(serial_mode_i), .htl_master_select_i(htl_i),
    .incremental_sim_en_o(inc_en), .master_input_en_o(mst_en),
    .frame_active_o(act));
  // ----------------------------------------------------------------------
  // Wire monitor
  // ----------------------------------------------------------------------
  always @(posedge clk_i) begin
    if (act === 1'b1 && serial_mode_i === 1'b0) saw_act = 1'b1;
    if (ssi_link_if_i.ssi_clk !== mprev) begin
      if (mon_on && ssi_link_if_i.ssi_clk !== idle_lvl) begin
        pulses = pulses + 1;
        if (smp_first && pulses > 1)
          wire_word = {wire_word[30:0], ssi_link_if_i.ssi_data};
      end else if (mon_on) begin
        if (!smp_first && pulses > 1)
          wire_word = {wire_word[30:0], ssi_link_if_i.ssi_data};
        if (pulses == 1) half_meas = 32'(run + 1);
      end
      run = 0;
    end else run = run + 1;
    mprev = ssi_link_if_i.ssi_clk;
  end
  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_bit(input logic got, input logic exp);
    cmp_word(32'(got), 32'(exp));
  endtask
  task automatic bus(input logic wr, input logic [31:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge clk_i); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_i); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic run_frame(input int i, input logic [2:0] code,
                           input logic [4:0] ctl);
    logic [31:0] r, w, mt, ma, cfg;
    logic [11:0] t0;
    logic [19:0] a0;
    int tn, an, hz;
    tn = (code == 3'h1) ? 8 : (code == 3'h2 || code == 3'h4) ? 10 : 12;
    an = (code == 3'h1) ? 16 : (code == 3'h2) ? 20 :
         (code == 3'h3 || code == 3'h4) ? 13 : 12;
    hz = (ctl[1:0] == 2'h0) ? RATE_0_HZ : (ctl[1:0] == 2'h1) ? RATE_1_HZ :
         (ctl[1:0] == 2'h2) ? RATE_2_HZ : RATE_3_HZ;
    t0 = 12'hB3D + 12'(i * 291);
    a0 = 20'hC5A69 + 20'(i * 4099);
    mt = (32'h1 << tn) - 32'h1;
    ma = (32'h1 << an) - 32'h1;
    cfg = {19'h00000, ctl, 5'h00, code};
    // Slave config moves first so the master's idle change is no pulse.
    turns_i <= t0;
    angle_i <= a0;
    code_i <= {5'h00, code};
    ctl_i <= {3'h0, ctl};
    repeat (4) @(posedge clk_i);
    bus(1'b1, 32'(REG_CONFIG), cfg, r);
    bus(1'b0, 32'(REG_CONFIG), 32'h0, r);
    cmp_word(r, cfg);
    idle_lvl = ctl[2];
    smp_first = ctl[3];
    pulses = 0;
    wire_word = 32'h0;
    mon_on = 1'b1;
    bus(1'b1, 32'(REG_COMMAND), 32'h1, r);
    do @(posedge clk_i); while (act !== 1'b1);
    turns_i <= ~t0;
    angle_i <= ~a0;
    do bus(1'b0, 32'(REG_STATUS), 32'h0, r); while (r !== 32'h2);
    mon_on = 1'b0;
    bus(1'b1, 32'(REG_STATUS), 32'h3, r);
    bus(1'b0, 32'(REG_STATUS), 32'h0, r);
    cmp_word(r, 32'h0);
    bus(1'b0, 32'(REG_TURNS), 32'h0, r);
    cmp_word(r, 32'(t0) & mt);
    bus(1'b0, 32'(REG_ANGLE), 32'h0, r);
    cmp_word(r, 32'(a0) & ma);
    w = ((32'(t0) & mt) << an) | (32'(a0) & ma);
    if (ctl[4]) w = w ^ (w >> 1);
    cmp_word(wire_word, w);
    cmp_word(half_meas, 32'(CLK_HZ / (2 * hz)));
    case (code)
      3'h1: cmp_word(32'(pulses), 32'h19);
      3'h2: cmp_word(32'(pulses), 32'h1F);
      3'h3: cmp_word(32'(pulses), 32'h1A);
      3'h4: cmp_word(32'(pulses), 32'h18);
      default: cmp_word(32'(pulses), 32'h19);
    endcase
    $display("test frame %0d done", i);
  endtask
  // ----------------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------------
  initial begin
    logic [31:0] r;
    rst_b_i = 1'b0;
    {hsel, hwrite, haddr, hwdata, htrans} = '0;
    hsize = 3'h2;
    turns_i = 12'h000;
    angle_i = 20'h00000;
    code_i = 8'h00;
    ctl_i = 8'h00;
    serial_mode_i = 1'b1;
    htl_i = 1'b0;
    {mon_on, idle_lvl, smp_first, mprev, saw_act} = '0;
    {wire_word, half_meas} = '0;
    repeat (12) @(posedge clk_i);
    rst_b_i <= 1'b1;
    @(posedge clk_i);
    for (int k = 0; k < 4; k++) begin
      serial_mode_i <= k[0];
      htl_i <= k[1];
      repeat (3) @(posedge clk_i);
      cmp_bit(inc_en, 1'(!k[0] && !k[1]));
      cmp_bit(mst_en, 1'(!k[1]));
      cmp_bit(ssi_link_if_i.ssi_data_en, 1'(k[0] && !k[1]));
    end
    $display("test enables done");
    bus(1'b1, 32'h0000_0020, 32'hFFFF_FFFF, r);
    bus(1'b0, 32'h0000_0020, 32'h0, r);
    cmp_word(r, 32'h0);
    cmp_bit(hresp, 1'b0);
    $display("test unmapped done");
    serial_mode_i <= 1'b0;
    htl_i <= 1'b0;
    bus(1'b1, 32'(REG_CONFIG), 32'h0000_0300, r);
    bus(1'b1, 32'(REG_COMMAND), 32'h1, r);
    do bus(1'b0, 32'(REG_STATUS), 32'h0, r); while (r !== 32'h2);
    bus(1'b1, 32'(REG_STATUS), 32'h2, r);
    cmp_bit(saw_act, 1'b0);
    $display("test disabled done");
    serial_mode_i <= 1'b1;
    run_frame(0, 3'h0, 5'b00000);
    run_frame(1, 3'h1, 5'b11101);
    run_frame(2, 3'h2, 5'b01010);
    run_frame(3, 3'h3, 5'b10111);
    run_frame(4, 3'h4, 5'b00011);
    run_frame(5, 3'h7, 5'b11011);
    give_verdict();
  end
  initial begin
    repeat (80000) @(posedge clk_i);
    mismatches++;
    $display("watchdog expired");
    give_verdict();
  end
endmodule
`default_nettype wire
